//--- core/power_seq_map.svh
`ifndef POWER_SEQ_MAP_SVH
`define POWER_SEQ_MAP_SVH

// register bus geometry
`define PSG_ADDR_W 10
`define PSG_DATA_W 32

// register indexes (byte address is four times the index)
`define PSG_PGCTL_IDX 8'h27
`define PSG_RSCTL_IDX 8'h28
`define PSG_STAT_IDX 8'h29

// power-good delay control fields and reset values
`define PSG_PGCTL_SEL_BIT 0
`define PSG_PGCTL_LOCK_BIT 1
`define PSG_PGCTL_SEL_RST 1'b1
`define PSG_PGCTL_LOCK_RST 1'b0

// resume reset control field and reset value
`define PSG_RSCTL_LEVEL_BIT 0
`define PSG_RSCTL_LEVEL_RST 1'b1

// status fields
`define PSG_STAT_S3_BIT 0
`define PSG_STAT_S5_BIT 1
`define PSG_STAT_SPG_BIT 2
`define PSG_STAT_RAIL_BIT 3
`define PSG_STAT_DONE_BIT 4
`define PSG_STAT_RSM_BIT 5
`define PSG_STAT_SON_BIT 6
`define PSG_STAT_RSW_BIT 7
`define PSG_STAT_HELD_BIT 8
`define PSG_STAT_PGO_BIT 9

// bus responses
`define PSG_RESP_OKAY 2'h0
`define PSG_RESP_SLVERR 2'h2

// timing: clock rate and delays in their own units
`define PSG_CLK_KHZ 200000
`define PSG_PG_DELAY_MS 100
`define PSG_RSM_DELAY_MS 30
`define PSG_PG_DELAY_CYC (`PSG_PG_DELAY_MS * `PSG_CLK_KHZ)
`define PSG_RSM_DELAY_CYC (`PSG_RSM_DELAY_MS * `PSG_CLK_KHZ)
`define PSG_TIMER_W 25

`endif

//--- core/power_seq_pkg.sv
package power_seq_pkg;

  // pin levels sampled together through the synchroniser
  typedef struct packed {
    logic sleep3;
    logic sleep5;
    logic supply_pg;
    logic rail_ok;
    logic supply_on;
    logic reg_switch;
  } pins_t;

  // resume reset sequencing, gray along hold -> wait -> run
  typedef enum logic [1:0] {
    RS_HOLD = 2'h0,
    RS_WAIT = 2'h1,
    RS_RUN = 2'h3
  } resume_state_t;

endpackage

//--- core/delay_timer.sv
`timescale 1ns/10ps
`include "power_seq_map.svh"

module delay_timer #(
  parameter int CW = `PSG_TIMER_W,
  parameter int unsigned CYCLES = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clear,
  input wire logic start,
  output logic done
);

  logic [CW-1:0] count_r;
  logic running_r;
  logic done_r;
  wire last = (count_r == CW'(CYCLES - 1));

  // clear beats start so a qualifying edge never runs on a dead condition
  always_ff @(posedge clock) begin
    if (!rstn || clear) begin
      count_r <= '0;
      running_r <= 1'b0;
      done_r <= 1'b0;
    end else if (start) begin
      count_r <= '0;
      running_r <= 1'b1;
      done_r <= 1'b0;
    end else if (running_r) begin
      count_r <= last ? count_r : count_r + CW'(1);
      running_r <= !last;
      done_r <= last;
    end
  end

  assign done = done_r;

endmodule // delay_timer

//--- core/power_sequencing_glue.sv
// Contract
// - supply-on pin drives low while sleep-S3 is high, floats otherwise.
// - system power-good goes low at once when sleep-S3 or supply power-good is low.
// - supply power-good rise with sleep-S3 high raises power-good, now or after delay.
// - delay select resets to the delayed rising transition.
// - delayed power-good stays low until the delay-elapsed indicator is set.
// - power-good and resume reset are held low while the standby rail rises.
// - power-good is low whenever resume reset is asserted.
// - power-good control register: bit 0 delay select, bit 1 lock.
// - once locked, select and lock ignore writes until standby power-on reset.
// - hardware only asserts resume reset; firmware level governs release.
// - resume reset releases a fixed delay after rail trip, only with rail present.
// - regulator-switch pin drives low only with supply power-good and sleep-S3 high.
// - held regulator switch is low when sleep-S5 or internal switch is low.
// - held regulator switch rises only on internal switch rise with sleep-S5 high.
// - with both high and no new rise the held output keeps its value.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`include "power_seq_map.svh"

module power_sequencing_glue #(
  parameter int unsigned PG_DELAY_CYCLES = `PSG_PG_DELAY_CYC,
  parameter int unsigned RSM_DELAY_CYCLES = `PSG_RSM_DELAY_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sleep_state3_n,
  input wire logic sleep_state5_n,
  input wire logic supply_power_good,
  input wire logic standby_rail_ok,
  input wire logic supply_on_n_in,
  output logic supply_on_n_out,
  output logic supply_on_n_oe_n,
  input wire logic regulator_switch_n_in,
  output logic regulator_switch_n_out,
  output logic regulator_switch_n_oe_n,
  output logic system_power_good_out,
  output logic resume_well_reset_n,
  output logic held_regulator_switch,
  input wire logic [`PSG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`PSG_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PSG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`PSG_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import power_seq_pkg::*;

  // ---------------- pin synchroniser ----------------
  power_seq_pkg::pins_t meta_r;
  power_seq_pkg::pins_t pins_r;
  power_seq_pkg::pins_t raw;

  assign raw.sleep3 = sleep_state3_n;
  assign raw.sleep5 = sleep_state5_n;
  assign raw.supply_pg = supply_power_good;
  assign raw.rail_ok = standby_rail_ok;
  assign raw.supply_on = supply_on_n_in;
  assign raw.reg_switch = regulator_switch_n_in;

  // two stages; only the second stage feeds logic
  always_ff @(posedge clock) begin
    if (!rstn) begin
      meta_r <= '0;
      pins_r <= '0;
    end else begin
      meta_r <= raw;
      pins_r <= meta_r;
    end
  end

  // named views of the synchronised levels
  wire s3 = pins_r.sleep3;
  wire s5 = pins_r.sleep5;
  wire spg = pins_r.supply_pg;
  wire rail = pins_r.rail_ok;

  // ---------------- registers and state ----------------
  logic spg_d_r;
  logic bf_d_r;
  logic armed_r;
  logic sel_r;
  logic lock_r;
  logic fw_level_r;
  logic pg_out_r;
  logic resume_r;
  logic held_r;
  logic son_oe_n_r;
  logic rsw_oe_n_r;
  power_seq_pkg::resume_state_t rs_state_r;
  power_seq_pkg::resume_state_t rs_state_nxt;
  logic pg_done;
  logic rsm_done;

  // internal regulator switch: low only while both supply good and S3 high
  wire both_on = spg & s3;
  wire bf_cut = ~both_on;
  wire bf_rise = bf_cut & ~bf_d_r;
  wire spg_rise = spg & ~spg_d_r;
  wire pg_qual = spg_rise & s3;
  wire pg_kill = ~spg | ~s3;

  // ---------------- power-good delay ----------------
  // a drop on either input restarts the whole interval on the next rise
  delay_timer #(
    .CW(`PSG_TIMER_W),
    .CYCLES(PG_DELAY_CYCLES)
  ) u_pg_delay (
    .clock(clock),
    .rstn(rstn),
    .clear(pg_kill),
    .start(pg_qual),
    .done(pg_done)
  );

  // power-good output next value
  wire pg_nxt = resume_r & s3 & spg & (armed_r | pg_qual) & (~sel_r | pg_done);

  // armed marks that the current high level came from a qualifying rise
  always_ff @(posedge clock) begin
    if (!rstn) begin
      spg_d_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      spg_d_r <= spg;
      armed_r <= pg_kill ? 1'b0 : (armed_r | pg_qual);
    end
  end

  // ---------------- resume reset ----------------
  delay_timer #(
    .CW(`PSG_TIMER_W),
    .CYCLES(RSM_DELAY_CYCLES)
  ) u_rsm_delay (
    .clock(clock),
    .rstn(rstn),
    .clear(~rail),
    .start(rs_state_r == RS_HOLD && rail),
    .done(rsm_done)
  );

  // loss of rail drops back to hold and restarts the fixed delay
  always_comb begin
    rs_state_nxt = rs_state_r;
    case (rs_state_r)
      RS_HOLD: begin
        if (rail) begin
          rs_state_nxt = RS_WAIT;
        end
      end
      RS_WAIT: begin
        if (!rail) begin
          rs_state_nxt = RS_HOLD;
        end else if (rsm_done) begin
          rs_state_nxt = RS_RUN;
        end
      end
      RS_RUN: begin
        if (!rail) begin
          rs_state_nxt = RS_HOLD;
        end
      end
      default: begin
        rs_state_nxt = RS_HOLD;
      end
    endcase
  end

  // hardware may only pull it low; release needs the firmware level too
  wire resume_nxt = (rs_state_r == RS_RUN) & rail & fw_level_r;

  // ---------------- regulator switch and held copy ----------------
  wire held_nxt = s5 & bf_cut & (held_r | bf_rise);

  // ---------------- output flops ----------------
  // synchronous reset holds every output in its safe state while the rail rises
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rs_state_r <= RS_HOLD;
      pg_out_r <= 1'b0;
      resume_r <= 1'b0;
      held_r <= 1'b0;
      bf_d_r <= 1'b1;
      son_oe_n_r <= 1'b1;
      rsw_oe_n_r <= 1'b1;
    end else begin
      rs_state_r <= rs_state_nxt;
      pg_out_r <= pg_nxt;
      resume_r <= resume_nxt;
      held_r <= held_nxt;
      bf_d_r <= bf_cut;
      son_oe_n_r <= ~s3;
      rsw_oe_n_r <= ~both_on;
    end
  end

  assign supply_on_n_out = 1'b0;
  assign regulator_switch_n_out = 1'b0;
  assign supply_on_n_oe_n = son_oe_n_r;
  assign regulator_switch_n_oe_n = rsw_oe_n_r;
  assign system_power_good_out = pg_out_r;
  assign resume_well_reset_n = resume_r;
  assign held_regulator_switch = held_r;

  // ---------------- axi4-lite slave ----------------
  logic awready_r;
  logic wready_r;
  logic aw_full_r;
  logic w_full_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [`PSG_DATA_W-1:0] rdata_r;
  logic [`PSG_ADDR_W-1:0] aw_addr_r;
  logic [`PSG_DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;

  wire aw_hs = s_axi_awvalid & awready_r;
  wire w_hs = s_axi_wvalid & wready_r;
  wire b_hs = bvalid_r & s_axi_bready;
  wire ar_hs = s_axi_arvalid & arready_r;
  wire r_hs = rvalid_r & s_axi_rready;
  wire do_write = aw_full_r & w_full_r & ~bvalid_r;

  // write decode on the word index
  wire [7:0] wr_idx = aw_addr_r[`PSG_ADDR_W-1:2];
  wire wr_pgctl = (wr_idx == `PSG_PGCTL_IDX);
  wire wr_rsctl = (wr_idx == `PSG_RSCTL_IDX);
  wire wr_stat = (wr_idx == `PSG_STAT_IDX);
  wire wr_hit = wr_pgctl | wr_rsctl | wr_stat;
  // a locked control register still answers okay, it simply keeps its bits
  wire pgctl_we = do_write & wr_pgctl & wstrb_r[0] & ~lock_r;
  wire rsctl_we = do_write & wr_rsctl & wstrb_r[0];

  // read decode
  wire [7:0] rd_idx = s_axi_araddr[`PSG_ADDR_W-1:2];
  wire rd_pgctl = (rd_idx == `PSG_PGCTL_IDX);
  wire rd_rsctl = (rd_idx == `PSG_RSCTL_IDX);
  wire rd_stat = (rd_idx == `PSG_STAT_IDX);
  wire rd_hit = rd_pgctl | rd_rsctl | rd_stat;

  logic [`PSG_DATA_W-1:0] pgctl_word;
  logic [`PSG_DATA_W-1:0] rsctl_word;
  logic [`PSG_DATA_W-1:0] stat_word;

  // read words, unused bits read zero
  always_comb begin
    pgctl_word = '0;
    pgctl_word[`PSG_PGCTL_SEL_BIT] = sel_r;
    pgctl_word[`PSG_PGCTL_LOCK_BIT] = lock_r;
    rsctl_word = '0;
    rsctl_word[`PSG_RSCTL_LEVEL_BIT] = fw_level_r;
    stat_word = '0;
    stat_word[`PSG_STAT_S3_BIT] = s3;
    stat_word[`PSG_STAT_S5_BIT] = s5;
    stat_word[`PSG_STAT_SPG_BIT] = spg;
    stat_word[`PSG_STAT_RAIL_BIT] = rail;
    stat_word[`PSG_STAT_DONE_BIT] = pg_done;
    stat_word[`PSG_STAT_RSM_BIT] = resume_r;
    stat_word[`PSG_STAT_SON_BIT] = pins_r.supply_on;
    stat_word[`PSG_STAT_RSW_BIT] = pins_r.reg_switch;
    stat_word[`PSG_STAT_HELD_BIT] = held_r;
    stat_word[`PSG_STAT_PGO_BIT] = pg_out_r;
  end

  wire [`PSG_DATA_W-1:0] rd_word = rd_pgctl ? pgctl_word :
                                   rd_rsctl ? rsctl_word :
                                   rd_stat ? stat_word : '0;

  // write channels: address and data taken independently, one write at a time
  always_ff @(posedge clock) begin
    if (!rstn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `PSG_RESP_OKAY;
      aw_addr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_addr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `PSG_RESP_OKAY : `PSG_RESP_SLVERR;
      end else if (b_hs) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // read channel: answer at the same edge that takes the address
  always_ff @(posedge clock) begin
    if (!rstn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= `PSG_RESP_OKAY;
      rdata_r <= '0;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? `PSG_RESP_OKAY : `PSG_RESP_SLVERR;
    end else if (r_hs) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // control bits; lock only falls with the power-on reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sel_r <= `PSG_PGCTL_SEL_RST;
      lock_r <= `PSG_PGCTL_LOCK_RST;
      fw_level_r <= `PSG_RSCTL_LEVEL_RST;
    end else begin
      if (pgctl_we) begin
        sel_r <= wdata_r[`PSG_PGCTL_SEL_BIT];
        lock_r <= wdata_r[`PSG_PGCTL_LOCK_BIT];
      end
      if (rsctl_we) begin
        fw_level_r <= wdata_r[`PSG_RSCTL_LEVEL_BIT];
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ---------------- assertions ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  son_drive_a: assert property (s3 |=> !supply_on_n_oe_n && !supply_on_n_out)
    else $error("supply-on not driven low with sleep-S3 high");
  son_float_a: assert property (!s3 |=> supply_on_n_oe_n)
    else $error("supply-on driven with sleep-S3 low");
  pg_drop_a: assert property ((!s3 || !spg) |=> !system_power_good_out)
    else $error("power-good high with an input low");
  pg_fast_a: assert property ((pg_qual && !sel_r && resume_r) |=> system_power_good_out)
    else $error("undelayed power-good did not rise");
  pg_wait_a: assert property ((sel_r && !pg_done) |=> !system_power_good_out)
    else $error("delayed power-good rose early");
  pg_resume_a: assert property (!resume_well_reset_n |=> !system_power_good_out)
    else $error("power-good high under resume reset");
  delay_clear_a: assert property (pg_kill |=> !pg_done)
    else $error("delay indicator survived an input drop");
  lock_hold_a: assert property (lock_r |=> lock_r && $stable(sel_r))
    else $error("locked delay bits changed");
  resume_fw_a: assert property (!fw_level_r |=> !resume_well_reset_n)
    else $error("resume reset released against firmware level");
  resume_rail_a: assert property (!rail |=> !resume_well_reset_n [*2])
    else $error("resume reset released without rail");
  regsw_drive_a: assert property (both_on |=> !regulator_switch_n_oe_n)
    else $error("regulator switch not driven");
  regsw_float_a: assert property (!both_on |=> regulator_switch_n_oe_n)
    else $error("regulator switch driven wrongly");
  held_low_a: assert property ((!s5 || !bf_cut) |=> !held_regulator_switch)
    else $error("held switch high with an input low");
  held_rise_a: assert property ((s5 && bf_rise) |=> held_regulator_switch)
    else $error("held switch missed a qualifying rise");
  held_keep_a: assert property ((s5 && bf_cut && !bf_rise) |=> $stable(held_regulator_switch))
    else $error("held switch changed without an edge");

  pg_delayed_c: cover property (sel_r && $rose(system_power_good_out));
  lock_set_c: cover property ($rose(lock_r));
  held_rise_c: cover property ($rose(held_regulator_switch));
  resume_rel_c: cover property ($rose(resume_well_reset_n));

endmodule // power_sequencing_glue

//--- sim/platform_model.sv
`timescale 1ns/10ps

module platform_model #(
  parameter int PS_DLY = 4,
  parameter int S3_GAP = 8,
  parameter int S5_LAG = 6
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic s3_cmd,
  input wire logic s5_cmd,
  input wire logic rail_cmd,
  input wire logic supply_fail,
  input wire logic supply_on_n_out,
  input wire logic supply_on_n_oe_n,
  input wire logic regulator_switch_n_out,
  input wire logic regulator_switch_n_oe_n,
  output logic sleep_state3_n,
  output logic sleep_state5_n,
  output logic supply_power_good,
  output logic standby_rail_ok,
  output logic supply_on_n_in,
  output logic regulator_switch_n_in
);
  int on_cnt_r = 0;
  int s5_hi_r = 0;
  int rsw_hi_r = 0;
  logic s3_r = 1'b0;
  logic s5_r = 1'b0;

  // both pins are open drain with board pull-ups, so a released pin reads high
  assign supply_on_n_in = supply_on_n_oe_n ? 1'b1 : supply_on_n_out;
  assign regulator_switch_n_in = regulator_switch_n_oe_n ? 1'b1 : regulator_switch_n_out;
  // supply reports good only after being held on for a while, or never while failing
  assign supply_power_good = (on_cnt_r >= PS_DLY) && !supply_fail;
  assign standby_rail_ok = rail_cmd;
  assign sleep_state3_n = s3_r;
  assign sleep_state5_n = s5_r;

  // chipset sequencing; counters saturate so long idle spans cannot wrap
  always_ff @(posedge clock) begin
    if (!rstn) begin
      on_cnt_r <= 0;
      s5_hi_r <= 0;
      rsw_hi_r <= 0;
      s3_r <= 1'b0;
      s5_r <= 1'b0;
    end else begin
      on_cnt_r <= supply_on_n_in ? 0 : (on_cnt_r < PS_DLY ? on_cnt_r + 1 : on_cnt_r);
      s5_hi_r <= s5_r ? (s5_hi_r < S3_GAP ? s5_hi_r + 1 : s5_hi_r) : 0;
      rsw_hi_r <= regulator_switch_n_in ? (rsw_hi_r < S5_LAG ? rsw_hi_r + 1 : rsw_hi_r) : 0;
      s3_r <= s3_cmd && (s5_hi_r >= S3_GAP);
      s5_r <= s5_cmd || (s5_r && (rsw_hi_r < S5_LAG));
    end
  end
endmodule // platform_model

//--- sim/tb_top.sv
`timescale 1ns/10ps
`include "power_seq_map.svh"

`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
  localparam int PGD = 20;
  localparam int RSMD = 30;
  localparam logic [`PSG_ADDR_W-1:0] PGCTL_A = {`PSG_PGCTL_IDX, 2'b00};
  localparam logic [`PSG_ADDR_W-1:0] RSCTL_A = {`PSG_RSCTL_IDX, 2'b00};
  localparam logic [`PSG_ADDR_W-1:0] STAT_A = {`PSG_STAT_IDX, 2'b00};
  localparam logic [`PSG_ADDR_W-1:0] BAD_A = 10'h3FC;

  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic s3_cmd = 1'b0, s5_cmd = 1'b0, rail_cmd = 1'b1, supply_fail = 1'b0;
  logic sleep_state3_n, sleep_state5_n, supply_power_good, standby_rail_ok;
  logic supply_on_n_in, supply_on_n_out, supply_on_n_oe_n;
  logic regulator_switch_n_in, regulator_switch_n_out, regulator_switch_n_oe_n;
  logic system_power_good_out, resume_well_reset_n, held_regulator_switch;
  logic [`PSG_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0;
  int checks_done = 0;

  // short delay parameters keep the run brief; every expectation uses them
  power_sequencing_glue #(.PG_DELAY_CYCLES(PGD), .RSM_DELAY_CYCLES(RSMD)) DUT (
    .clock, .rstn, .sleep_state3_n, .sleep_state5_n, .supply_power_good,
    .standby_rail_ok, .supply_on_n_in, .supply_on_n_out, .supply_on_n_oe_n,
    .regulator_switch_n_in, .regulator_switch_n_out, .regulator_switch_n_oe_n,
    .system_power_good_out, .resume_well_reset_n, .held_regulator_switch,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  platform_model PM (
    .clock, .rstn, .s3_cmd, .s5_cmd, .rail_cmd, .supply_fail, .supply_on_n_out,
    .supply_on_n_oe_n, .regulator_switch_n_out, .regulator_switch_n_oe_n,
    .sleep_state3_n, .sleep_state5_n, .supply_power_good, .standby_rail_ok,
    .supply_on_n_in, .regulator_switch_n_in);

  // 200 MHz clock
  initial begin
    forever #2.5 clock = ~clock;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // values read right after an edge are the ones the design saw at that edge
  function automatic logic sig(input int w);
    case (w)
      0: return system_power_good_out;
      1: return resume_well_reset_n;
      2: return held_regulator_switch;
      default: return supply_power_good;
    endcase
  endfunction

  task automatic wait_sig(input int w, input logic lvl, input int lim, output int n);
    n = 0;
    while (n < lim && sig(w) !== lvl) begin
      @(posedge clock);
      n++;
    end
  endtask

  // each channel is released at the edge that takes it
  task automatic axi_write(input logic [`PSG_ADDR_W-1:0] a, input logic [31:0] v,
                           output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clock);
      aw |= s_axi_awready;
      w |= s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [`PSG_ADDR_W-1:0] a, output logic [31:0] v,
                          output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    tick(20);
    `CHK("pg in reset", 1'b0, system_power_good_out)
    `CHK("rsm in reset", 1'b0, resume_well_reset_n)
    rstn <= 1'b1;
    wait_sig(1, 1'b1, RSMD + 40, n);
    `CHK("rsm delay", 1'b1, n >= RSMD && resume_well_reset_n === 1'b1)
    axi_read(PGCTL_A, d, r);
    `CHK("pgctl reset", 32'h1, d)
    axi_read(BAD_A, d, r);
    `CHK("unmapped", `PSG_RESP_SLVERR, r)
  endtask

  // supply glitch mid-wait must restart the whole delay
  task automatic t_delayed_up;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    s5_cmd <= 1'b1;
    s3_cmd <= 1'b1;
    wait_sig(3, 1'b1, 60, n);
    `CHK("son driven", 1'b0, supply_on_n_oe_n)
    tick(8);
    supply_fail <= 1'b1;
    tick(4);
    `CHK("pg glitch", 1'b0, system_power_good_out)
    supply_fail <= 1'b0;
    wait_sig(0, 1'b1, PGD + 20, n);
    `CHK("pg restart", 1'b1, n >= PGD - 2)
    `CHK("pg delayed", 1'b1, system_power_good_out)
    `CHK("rsw driven", 1'b0, regulator_switch_n_oe_n)
    `CHK("held low", 1'b0, held_regulator_switch)
    `CHK("son data", 1'b0, supply_on_n_out)
    `CHK("rsw data", 1'b0, regulator_switch_n_out)
    // all inputs high, delay elapsed, both pads pulled low, power good up
    axi_read(STAT_A, d, r);
    `CHK("status", 32'h23F, d)
    `CHK("status resp", `PSG_RESP_OKAY, r)
  endtask

  task automatic t_power_down;
    int n;
    s3_cmd <= 1'b0;
    wait_sig(0, 1'b0, 10, n);
    `CHK("pg drop s3", 1'b1, n <= 6)
    wait_sig(2, 1'b1, 10, n);
    `CHK("held rise", 1'b1, held_regulator_switch)
    `CHK("son float", 1'b1, supply_on_n_oe_n)
    `CHK("rsw float", 1'b1, regulator_switch_n_oe_n)
    s5_cmd <= 1'b0;
    wait_sig(2, 1'b0, 30, n);
    `CHK("held s5 low", 1'b0, held_regulator_switch)
    s5_cmd <= 1'b1;
    tick(12);
    `CHK("held no rise", 1'b0, held_regulator_switch)
  endtask

  task automatic t_no_delay;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    axi_write(PGCTL_A, 32'h0, r);
    axi_read(PGCTL_A, d, r);
    `CHK("sel clear", 32'h0, d)
    s3_cmd <= 1'b1;
    wait_sig(3, 1'b1, 60, n);
    wait_sig(0, 1'b1, 20, n);
    `CHK("pg no delay", 1'b1, n <= 6)
    supply_fail <= 1'b1;
    wait_sig(0, 1'b0, 10, n);
    `CHK("pg drop spg", 1'b1, n <= 6)
    supply_fail <= 1'b0;
    wait_sig(0, 1'b1, 20, n);
    `CHK("pg back", 1'b1, system_power_good_out)
  endtask

  task automatic t_resume_ctl;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    axi_write(RSCTL_A, 32'h0, r);
    axi_read(RSCTL_A, d, r);
    `CHK("fw level", 32'h0, d)
    wait_sig(1, 1'b0, 10, n);
    tick(3);
    `CHK("fw assert", 1'b0, resume_well_reset_n)
    `CHK("pg in rsm", 1'b0, system_power_good_out)
    tick(RSMD + 20);
    `CHK("hw holds", 1'b0, resume_well_reset_n)
    axi_write(RSCTL_A, 32'h1, r);
    wait_sig(1, 1'b1, RSMD + 40, n);
    `CHK("fw release", 1'b1, resume_well_reset_n)
    rail_cmd <= 1'b0;
    wait_sig(1, 1'b0, 10, n);
    tick(RSMD + 20);
    `CHK("no rail", 1'b0, resume_well_reset_n)
    rail_cmd <= 1'b1;
    wait_sig(1, 1'b1, RSMD + 40, n);
    `CHK("rail delay", 1'b1, n >= RSMD && resume_well_reset_n === 1'b1)
  endtask

  // lock survives writes and clears only on a fresh reset
  task automatic t_lock;
    logic [31:0] d;
    logic [1:0] r;
    axi_write(PGCTL_A, 32'h3, r);
    axi_write(PGCTL_A, 32'h0, r);
    `CHK("locked resp", `PSG_RESP_OKAY, r)
    axi_read(PGCTL_A, d, r);
    `CHK("lock holds", 32'h3, d)
    rstn <= 1'b0;
    tick(3);
    rstn <= 1'b1;
    axi_read(PGCTL_A, d, r);
    `CHK("lock cleared", 32'h1, d)
  endtask

  initial begin
    t_reset();
    t_delayed_up();
    t_power_down();
    t_no_delay();
    t_resume_ctl();
    t_lock();
    end_of_test();
  end

  // the scenarios need a few hundred cycles; this bound cuts a hang
  initial begin
    tick(20000);
    num_errors++;
    $display("FAIL watchdog expected done seen hang");
    end_of_test();
  end
endmodule // tb_top
